/* File: common/ppmc_pkg.sv */
// constants, codes and carriers for the port pin mode configuration block
`default_nettype none
package ppmc_pkg;
  // port widths and pin numbering across the joined 18-pin vector
  localparam int P0_PINS = 8;
  localparam int P1_PINS = 8;
  localparam int P3_PINS = 2;
  localparam int NPINS = P0_PINS + P1_PINS + P3_PINS;
  localparam int P1_BASE = P0_PINS;
  localparam int P3_BASE = P0_PINS + P1_PINS;
  localparam int RST_PIN_IDX = P1_BASE + 5;  // reset-shared input pin
  localparam int SCL_PIN_IDX = P1_BASE + 2;  // port1 bit2 clock pin
  localparam int SDA_PIN_IDX = P1_BASE + 3;  // port1 bit3 data pin

  // glitch suppression window: least time, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int GLITCH_NS = 20;
  localparam int GLITCH_CYCLES =
    (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // drive type selector {cfg_a, cfg_b}
  localparam logic [1:0] MODE_QUASI = 2'h0;
  localparam logic [1:0] MODE_PUSH = 2'h1;
  localparam logic [1:0] MODE_INPUT = 2'h2;
  localparam logic [1:0] MODE_OPEN = 2'h3;

  // register offsets
  localparam logic [3:0] ADDR_P0_LATCH = 4'h0;
  localparam logic [3:0] ADDR_P0_CFGA = 4'h1;
  localparam logic [3:0] ADDR_P0_CFGB = 4'h2;
  localparam logic [3:0] ADDR_P1_LATCH = 4'h3;
  localparam logic [3:0] ADDR_P1_CFGA = 4'h4;
  localparam logic [3:0] ADDR_P1_CFGB = 4'h5;
  localparam logic [3:0] ADDR_P3_LATCH = 4'h6;
  localparam logic [3:0] ADDR_P3_CFGA = 4'h7;
  localparam logic [3:0] ADDR_P3_CFGB = 4'h8;
  localparam logic [3:0] ADDR_P0_DIS = 4'h9;
  localparam logic [3:0] ADDR_P0_PIN = 4'ha;
  localparam logic [3:0] ADDR_P1_PIN = 4'hb;
  localparam logic [3:0] ADDR_P3_PIN = 4'hc;
  localparam logic [3:0] ADDR_IO_COUNT = 4'hd;

  // values after reset
  localparam logic [NPINS-1:0] CFGA_RST = 18'h3ffff;
  localparam logic [NPINS-1:0] CFGB_RST = 18'h00000;
  localparam logic [NPINS-1:0] LATCH_RST = 18'h3ffff;
  localparam logic [7:0] P0_DIS_RST = 8'h00;
  localparam logic [7:0] P0_DIS_MASK = 8'h3e;  // only bits 1..5 exist

  // general i/o pin counts by clock source, less one with external reset
  localparam logic [1:0] CLKSRC_INTERNAL = 2'h0;
  localparam logic [1:0] CLKSRC_EXTCLK = 2'h1;
  localparam logic [1:0] CLKSRC_CRYSTAL = 2'h2;
  localparam logic [4:0] IO_CNT_INTERNAL = 5'h12;
  localparam logic [4:0] IO_CNT_EXTCLK = 5'h11;
  localparam logic [4:0] IO_CNT_CRYSTAL = 5'h10;

  // one pin driver: oe_n low drives out_val strongly
  typedef struct packed {
    logic out_val;
    logic oe_n;
    logic weak_pu;
  } ppmc_drive_s;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ppmc_bus_s;
endpackage
`default_nettype wire

/* File: logic/ppmc_port_config.sv */
// port pin drive type configuration, glitch filters and register port
`timescale 1ns/1ps
`default_nettype none
module ppmc_port_config #(
  parameter int GLITCH_LEN = ppmc_pkg::GLITCH_CYCLES
) (
  // clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst,
  // register port
  input  wire ppmc_pkg::ppmc_bus_s                  bus,
  output logic [7:0]                                rd_data,
  // straps, caught while reset is high
  input  wire logic [1:0]                           clk_src,
  input  wire logic                                 ext_rst_en,
  // raw pin levels
  input  wire logic [ppmc_pkg::P0_PINS-1:0]         p0_in,
  input  wire logic [ppmc_pkg::P1_PINS-1:0]         p1_in,
  input  wire logic [ppmc_pkg::P3_PINS-1:0]         p3_in,
  // pin drivers
  output ppmc_pkg::ppmc_drive_s [ppmc_pkg::P0_PINS-1:0] p0_drive,
  output ppmc_pkg::ppmc_drive_s [ppmc_pkg::P1_PINS-1:0] p1_drive,
  output ppmc_pkg::ppmc_drive_s [ppmc_pkg::P3_PINS-1:0] p3_drive,
  // analog hookup: high where port 0 digital input is cut
  output logic [ppmc_pkg::P0_PINS-1:0]              p0_input_off
);
  import ppmc_pkg::*;

  // counters are three bits wide and assertions look two samples back
  if (GLITCH_LEN < 2 || GLITCH_LEN > 7) begin : g_bad_len
    $error("GLITCH_LEN must lie in 2..7");
  end

  // decode one pin's driver from its selector and latch
  function automatic ppmc_drive_s drive_of(input logic [1:0] mode,
                                           input logic latch);
    ppmc_drive_s d;
    d = '{out_val: 1'b0, oe_n: 1'b1, weak_pu: 1'b0};
    case (mode)
      MODE_QUASI: begin
        d.weak_pu = latch;
        d.oe_n = latch;
      end
      MODE_PUSH: begin
        d.out_val = latch;
        d.oe_n = 1'b0;
      end
      MODE_OPEN: d.oe_n = latch;  // pull-ups off
      default: d.oe_n = 1'b1;     // no driver at all
    endcase
    return d;
  endfunction

  // configuration state
  logic [NPINS-1:0]        latch_r, latch_nxt;
  logic [NPINS-1:0]        cfga_r, cfga_nxt;
  logic [NPINS-1:0]        cfgb_r, cfgb_nxt;
  logic [7:0]              dis_r, dis_nxt;
  ppmc_drive_s [NPINS-1:0] drive_r, drive_nxt;
  logic [4:0]              io_count_r, io_count_nxt;
  logic [7:0]              rd_data_r, rd_data_nxt;
  // input filter state
  logic [NPINS-1:0]        pin_raw;
  logic [NPINS-1:0]        filt_r, filt_nxt;
  logic [2:0]              cnt_r [NPINS];
  logic [2:0]              cnt_nxt [NPINS];
  logic [NPINS-1:0]        pin_seen;
  logic [NPINS-1:0]        oe_n_vec;

  assign pin_raw = {p3_in, p1_in, p0_in};

  // register writes; the selector pair of each pin is {cfga, cfgb}
  always_comb begin
    latch_nxt = latch_r;
    cfga_nxt = cfga_r;
    cfgb_nxt = cfgb_r;
    dis_nxt = dis_r;
    if (bus.wr) begin
      case (bus.addr)
        ADDR_P0_LATCH: latch_nxt[P0_PINS-1:0] = bus.wdata;
        ADDR_P1_LATCH: latch_nxt[P3_BASE-1:P1_BASE] = bus.wdata;
        ADDR_P3_LATCH: latch_nxt[NPINS-1:P3_BASE] = bus.wdata[1:0];
        ADDR_P0_CFGA: cfga_nxt[P0_PINS-1:0] = bus.wdata;
        ADDR_P0_CFGB: cfgb_nxt[P0_PINS-1:0] = bus.wdata;
        ADDR_P1_CFGA: cfga_nxt[P3_BASE-1:P1_BASE] = bus.wdata;
        ADDR_P1_CFGB: cfgb_nxt[P3_BASE-1:P1_BASE] = bus.wdata;
        ADDR_P3_CFGA: cfga_nxt[NPINS-1:P3_BASE] = bus.wdata[1:0];
        ADDR_P3_CFGB: cfgb_nxt[NPINS-1:P3_BASE] = bus.wdata[1:0];
        ADDR_P0_DIS: dis_nxt = bus.wdata & P0_DIS_MASK;
        default: dis_nxt = dis_r;  // read-only or unmapped: no effect
      endcase
    end
    // reset-shared pin pinned to input-only whatever is written
    cfga_nxt[RST_PIN_IDX] = 1'b1;
    cfgb_nxt[RST_PIN_IDX] = 1'b0;
    // cfga forced high leaves only input-only or open-drain
    cfga_nxt[SCL_PIN_IDX] = 1'b1;
    cfga_nxt[SDA_PIN_IDX] = 1'b1;
  end

  // drivers follow the next values so they never lag the registers
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      drive_nxt[i] = drive_of({cfga_nxt[i], cfgb_nxt[i]}, latch_nxt[i]);
    end
  end

  // strap decode for the available general i/o count
  always_comb begin
    case (clk_src)
      CLKSRC_INTERNAL: io_count_nxt = IO_CNT_INTERNAL;
      CLKSRC_EXTCLK: io_count_nxt = IO_CNT_EXTCLK;
      default: io_count_nxt = IO_CNT_CRYSTAL;
    endcase
    if (ext_rst_en) begin
      io_count_nxt = io_count_nxt - 5'h01;
    end
  end

  // configuration registers; reset leaves every pin input-only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latch_r <= LATCH_RST;
      cfga_r <= CFGA_RST;
      cfgb_r <= CFGB_RST;
      dis_r <= P0_DIS_RST;
      drive_r <= '{default: '{out_val: 1'b0, oe_n: 1'b1, weak_pu: 1'b0}};
      io_count_r <= io_count_nxt;  // straps caught by the clock
    end else begin
      latch_r <= latch_nxt;
      cfga_r <= cfga_nxt;
      cfgb_r <= cfgb_nxt;
      dis_r <= dis_nxt;
      drive_r <= drive_nxt;
      io_count_r <= io_count_r;
    end
  end

  // glitch filter: a new level is taken only after GLITCH_LEN samples
  always_comb begin
    filt_nxt = filt_r;
    for (int i = 0; i < NPINS; i++) begin
      cnt_nxt[i] = 3'h0;
      if (pin_raw[i] != filt_r[i]) begin
        if (cnt_r[i] == 3'(GLITCH_LEN - 1)) begin
          filt_nxt[i] = pin_raw[i];
        end else begin
          cnt_nxt[i] = cnt_r[i] + 3'h1;
        end
      end
    end
  end

  // filter state; pins float high-ish so the idle level is taken as one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filt_r <= {NPINS{1'b1}};
      for (int i = 0; i < NPINS; i++) begin
        cnt_r[i] <= 3'h0;
      end
    end else begin
      filt_r <= filt_nxt;
      for (int i = 0; i < NPINS; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  // cut port 0 inputs read as zero so a floating analog level is harmless
  assign pin_seen = filt_r & ~{10'h000, dis_r};

  // read mux, answered in the cycle after the strobe
  always_comb begin
    rd_data_nxt = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_P0_LATCH: rd_data_nxt = latch_r[P0_PINS-1:0];
        ADDR_P1_LATCH: rd_data_nxt = latch_r[P3_BASE-1:P1_BASE];
        ADDR_P3_LATCH: rd_data_nxt = {6'h00, latch_r[NPINS-1:P3_BASE]};
        ADDR_P0_CFGA: rd_data_nxt = cfga_r[P0_PINS-1:0];
        ADDR_P0_CFGB: rd_data_nxt = cfgb_r[P0_PINS-1:0];
        ADDR_P1_CFGA: rd_data_nxt = cfga_r[P3_BASE-1:P1_BASE];
        ADDR_P1_CFGB: rd_data_nxt = cfgb_r[P3_BASE-1:P1_BASE];
        ADDR_P3_CFGA: rd_data_nxt = {6'h00, cfga_r[NPINS-1:P3_BASE]};
        ADDR_P3_CFGB: rd_data_nxt = {6'h00, cfgb_r[NPINS-1:P3_BASE]};
        ADDR_P0_DIS: rd_data_nxt = dis_r;
        ADDR_P0_PIN: rd_data_nxt = pin_seen[P0_PINS-1:0];
        ADDR_P1_PIN: rd_data_nxt = pin_seen[P3_BASE-1:P1_BASE];
        ADDR_P3_PIN: rd_data_nxt = {6'h00, pin_seen[NPINS-1:P3_BASE]};
        ADDR_IO_COUNT: rd_data_nxt = {3'h0, io_count_r};
        default: rd_data_nxt = 8'h00;  // unmapped reads as zero
      endcase
    end
  end

  // read data register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // outputs
  assign rd_data = rd_data_r;
  assign p0_drive = drive_r[P0_PINS-1:0];
  assign p1_drive = drive_r[P3_BASE-1:P1_BASE];
  assign p3_drive = drive_r[NPINS-1:P3_BASE];
  assign p0_input_off = dis_r;

  // high where a pin has no strong driver and no weak pull-up: input-only, or open-drain with its latch high
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      oe_n_vec[i] = drive_r[i].oe_n & ~drive_r[i].weak_pu;
    end
  end

  // checks on the reset pin, the bus pins, reset state and pin count
  a_rst_pin_input:
    assert property (@(posedge sys_clk) disable iff (rst)
      drive_r[RST_PIN_IDX].oe_n && !drive_r[RST_PIN_IDX].weak_pu &&
      $stable(cfga_r[RST_PIN_IDX]))
    else $error("reset-shared pin not input-only");
  a_bus_pins_limited:
    assert property (@(posedge sys_clk) disable iff (rst)
      cfga_r[SCL_PIN_IDX] && cfga_r[SDA_PIN_IDX] &&
      !drive_r[SCL_PIN_IDX].weak_pu && !drive_r[SDA_PIN_IDX].weak_pu &&
      !drive_r[SCL_PIN_IDX].out_val && !drive_r[SDA_PIN_IDX].out_val)
    else $error("clock or data pin driven high");
  a_reset_all_input:
    assert property (@(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> (&oe_n_vec) ##1 ((&oe_n_vec) || $past(bus.wr)))
    else $error("pin driven right after reset");
  a_dis_cleared:
    assert property (@(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> dis_r == 8'h00 && (dis_r & 8'hc1) == 8'h00)
    else $error("input disable not clear after reset");
  a_io_count_range:
    assert property (@(posedge sys_clk) disable iff (rst)
      io_count_r >= 5'h0f && io_count_r <= 5'h12)
    else $error("pin count outside 15..18");

  // register port: writes land at once, idle cycles read as zero
  a_cfg_write_lands:
    assert property (@(posedge sys_clk) disable iff (rst)
      bus.wr && bus.addr == ADDR_P0_CFGA |=>
      cfga_r[P0_PINS-1:0] == $past(bus.wdata))
    else $error("port 0 selector write lost");
  a_rd_idle_zero:
    assert property (@(posedge sys_clk) disable iff (rst)
      !$past(bus.rd) |-> rd_data_r == 8'h00)
    else $error("read data shown without a read");
  a_dis_fixed_bits:
    assert property (@(posedge sys_clk) disable iff (rst)
      (dis_r & ~P0_DIS_MASK) == 8'h00 && p0_input_off == dis_r)
    else $error("input disable bit outside 1..5 set");

  // per-pin checks on drive decode and glitch filter
  for (genvar g = 0; g < NPINS; g++) begin : g_chk
    a_quasi_weak:
      assert property (@(posedge sys_clk) disable iff (rst)
        {cfga_r[g], cfgb_r[g]} == MODE_QUASI |->
        drive_r[g].weak_pu == latch_r[g] && drive_r[g].oe_n == latch_r[g])
      else $error("quasi pin drive wrong");
    a_open_drain:
      assert property (@(posedge sys_clk) disable iff (rst)
        {cfga_r[g], cfgb_r[g]} == MODE_OPEN |-> !drive_r[g].weak_pu &&
        drive_r[g].oe_n == latch_r[g] && !drive_r[g].out_val)
      else $error("open-drain pin drive wrong");
    a_input_float:
      assert property (@(posedge sys_clk) disable iff (rst)
        {cfga_r[g], cfgb_r[g]} == MODE_INPUT |->
        drive_r[g].oe_n && !drive_r[g].weak_pu)
      else $error("input-only pin has a driver");
    a_push_pull:
      assert property (@(posedge sys_clk) disable iff (rst)
        {cfga_r[g], cfgb_r[g]} == MODE_PUSH |->
        !drive_r[g].oe_n && drive_r[g].out_val == latch_r[g])
      else $error("push-pull pin drive wrong");
    a_glitch_held:
      assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) && $changed(filt_r[g]) |->
        $past(pin_raw[g], 1) == filt_r[g] &&
        $past(pin_raw[g], 2) == filt_r[g])
      else $error("short pulse reached filtered input");
  end
endmodule // ppmc_port_config
`default_nettype wire

/* File: tb/ppmc_board.sv */
// board model: pin levels from the block's drivers, pull-ups and pushers
`timescale 1ns/1ps
`default_nettype none
module ppmc_board (
  // clock
  input  wire logic                                     sys_clk,
  // block drivers, port 3 at the top, port 0 at the bottom
  input  wire ppmc_pkg::ppmc_drive_s [ppmc_pkg::NPINS-1:0] drv,
  // board circuitry
  input  wire logic [ppmc_pkg::NPINS-1:0]               pull_res,
  input  wire logic [ppmc_pkg::NPINS-1:0]               ext_en,
  input  wire logic [ppmc_pkg::NPINS-1:0]               ext_val,
  // resulting levels
  output logic [ppmc_pkg::NPINS-1:0]                    lvl
);
  import ppmc_pkg::*;
  logic [NPINS-1:0] last_r;
  // strong drive wins, then outside pusher, then pull-ups
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (!drv[i].oe_n) lvl[i] = drv[i].out_val;
      else if (ext_en[i]) lvl[i] = ext_val[i];
      // resistor to supply lifts an open-drain output
      else if (drv[i].weak_pu || pull_res[i]) lvl[i] = 1'b1;
      // floating pin: never hand back the old level
      else lvl[i] = ~last_r[i];
    end
  end
  // remember levels so a floating pin keeps moving
  always_ff @(posedge sys_clk) begin
    last_r <= lvl;
  end
endmodule // ppmc_board
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the port pin mode configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ppmc_pkg::*;
  logic sys_clk, rst, ext_rst_en;
  logic [1:0] clk_src;
  ppmc_bus_s bus;
  logic [7:0] rd_data, p0_input_off, rv;
  ppmc_drive_s [P0_PINS-1:0] p0_drive;
  ppmc_drive_s [P1_PINS-1:0] p1_drive;
  ppmc_drive_s [P3_PINS-1:0] p3_drive;
  logic [NPINS-1:0] lvl, pull_res, ext_en, ext_val;
  int err_total, n_checks;

  ppmc_port_config ppmc_port_config_i (.sys_clk(sys_clk), .rst(rst),
    .bus(bus), .rd_data(rd_data), .clk_src(clk_src),
    .ext_rst_en(ext_rst_en), .p0_in(lvl[7:0]), .p1_in(lvl[15:8]),
    .p3_in(lvl[17:16]), .p0_drive(p0_drive), .p1_drive(p1_drive),
    .p3_drive(p3_drive), .p0_input_off(p0_input_off));
  ppmc_board ppmc_board_i (.sys_clk(sys_clk),
    .drv({p3_drive, p1_drive, p0_drive}), .pull_res(pull_res),
    .ext_en(ext_en), .ext_val(ext_val), .lvl(lvl));

  // clock at 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(rv, e);
  endtask

  task automatic do_reset(input int n);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (n) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  // driver of one pin against its mode and latch bit
  task automatic drv_chk(input ppmc_drive_s d, input logic [1:0] m,
                         input logic l);
    logic [1:0] e;
    e = (m == MODE_QUASI) ? {l, l} : (m == MODE_PUSH) ? 2'h0 :
        (m == MODE_INPUT) ? 2'h2 : {l, 1'b0};
    chk({d.oe_n, d.weak_pu}, e);
    if (!e[1]) chk(d.out_val, (m == MODE_PUSH) ? l : 1'b0);
  endtask

  task automatic t_reset_vals();
    #1;
    for (int i = 0; i < P0_PINS; i++) drv_chk(p0_drive[i], MODE_INPUT, 1);
    for (int i = 0; i < P1_PINS; i++) drv_chk(p1_drive[i], MODE_INPUT, 1);
    for (int i = 0; i < P3_PINS; i++) drv_chk(p3_drive[i], MODE_INPUT, 1);
    rd_chk(ADDR_P0_CFGA, 8'hff);
    rd_chk(ADDR_P1_CFGB, 8'h00);
    rd_chk(ADDR_P3_CFGA, 8'h03);
    rd_chk(ADDR_P0_DIS, 8'h00);
    rd_chk(4'hf, 8'h00);
  endtask

  // every drive code on port 0, two latch patterns each
  task automatic t_modes();
    logic [7:0] pat;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        pat = k ? 8'ha5 : 8'h5a;
        wr(ADDR_P0_CFGA, {8{m[1]}});
        wr(ADDR_P0_CFGB, {8{m[0]}});
        wr(ADDR_P0_LATCH, pat);
        #1;
        for (int i = 0; i < P0_PINS; i++) drv_chk(p0_drive[i], 2'(m), pat[i]);
        repeat (5) @(posedge sys_clk);
        rd_chk(ADDR_P0_PIN, (m == MODE_INPUT) ? 8'hff : pat);
      end
    end
  endtask

  // reset-shared and bus pins ignore what they are not allowed
  task automatic t_restrict();
    wr(ADDR_P1_LATCH, 8'hff);
    wr(ADDR_P1_CFGA, 8'h00);
    wr(ADDR_P1_CFGB, 8'hff);
    #1;
    for (int i = 0; i < P1_PINS; i++)
      drv_chk(p1_drive[i], (i == 5) ? MODE_INPUT :
              (i == 2 || i == 3) ? MODE_OPEN : MODE_PUSH, 1);
    rd_chk(ADDR_P1_CFGA, 8'h2c);
    rd_chk(ADDR_P1_CFGB, 8'hdf);
    wr(ADDR_P1_CFGB, 8'h00);
    wr(ADDR_P1_LATCH, 8'h00);
    #1;
    for (int i = 0; i < P1_PINS; i++)
      drv_chk(p1_drive[i], (i == 5 || i == 2 || i == 3) ? MODE_INPUT :
              MODE_QUASI, 0);
  endtask

  // port 3: two pins, upper write bits dropped, one push-pull, one input
  task automatic t_port3();
    wr(ADDR_P3_CFGA, 8'hfe);
    wr(ADDR_P3_CFGB, 8'hfd);
    wr(ADDR_P3_LATCH, 8'h01);
    #1;
    drv_chk(p3_drive[0], MODE_PUSH, 1'b1);
    drv_chk(p3_drive[1], MODE_INPUT, 1'b0);
    rd_chk(ADDR_P3_CFGA, 8'h02);
    rd_chk(ADDR_P3_CFGB, 8'h01);
    rd_chk(ADDR_P3_LATCH, 8'h01);
    repeat (4) @(posedge sys_clk);
    rd_chk(ADDR_P3_PIN, 8'h03);
  endtask

  task automatic t_disable();
    wr(ADDR_P0_CFGA, 8'hff);
    wr(ADDR_P0_CFGB, 8'h00);
    wr(ADDR_P0_DIS, 8'hff);
    #1 chk(p0_input_off, 8'h3e);
    rd_chk(ADDR_P0_DIS, 8'h3e);
    repeat (4) @(posedge sys_clk);
    rd_chk(ADDR_P0_PIN, 8'hc1);
  endtask

  // pin count from every strap pair, each caught by a fresh reset
  task automatic t_straps();
    logic [7:0] n_io;
    for (int c = 0; c < 4; c++) begin
      for (int e = 0; e < 2; e++) begin
        @(posedge sys_clk);
        clk_src <= 2'(c);
        ext_rst_en <= 1'(e);
        do_reset(3);
        #1 chk(p0_input_off, 8'h00);
        wr(ADDR_IO_COUNT, 8'h00);
        n_io = 8'((c == 3) ? 16 - e : 18 - c - e);
        rd_chk(ADDR_IO_COUNT, n_io);
        rd_chk(ADDR_P0_DIS, 8'h00);
      end
    end
  endtask

  // one-cycle dip is swallowed, a held one gets through
  task automatic t_glitch();
    repeat (4) @(posedge sys_clk);
    ext_en[0] <= 1'b1;
    @(posedge sys_clk);
    ext_en[0] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_chk(ADDR_P0_PIN, 8'hff);
    @(posedge sys_clk);
    ext_en[0] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_chk(ADDR_P0_PIN, 8'hfe);
    @(posedge sys_clk);
    ext_en[0] <= 1'b0;
  endtask

  // main sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    rst = 1'b1;
    bus = '0;
    clk_src = CLKSRC_INTERNAL;
    ext_rst_en = 1'b0;
    pull_res = '1;
    ext_en = '0;
    ext_val = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_vals();
    t_modes();
    t_restrict();
    t_port3();
    t_disable();
    t_straps();
    t_glitch();
    close_out();
  end

  // watchdog, well past the few hundred cycles the tests need
  initial begin
    #200us;
    err_total++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
